// file: core/radio_seq_pkg.sv
// Purpose: shared constants and types for the radio packet sequencer
// Assumes: APB register map, 200 MHz mclk
// Notes: offsets are register indices; byte address is index times four
package radio_seq_pkg;
	localparam int CLK_MHZ = 200;
	localparam int US_CYCLES = CLK_MHZ;
	localparam int CCA_PERIOD_US = 128;
	localparam int CCA_PERIOD_CYC = CCA_PERIOD_US * US_CYCLES;
	localparam int EXT_STEP_US = 4;
	localparam int DLY_STEP_US = 1;

	localparam logic [9:0] IDX_CCA_OPT = 10'h106;
	localparam logic [9:0] IDX_BUF_CFG = 10'h107;
	localparam logic [9:0] IDX_PKT_FMT = 10'h108;
	localparam logic [9:0] IDX_RX_DLY = 10'h109;
	localparam logic [9:0] IDX_TX_DLY = 10'h10A;
	localparam logic [9:0] IDX_DLY_EXT = 10'h10B;
	localparam logic [9:0] IDX_FMT_SEL = 10'h13E;
	localparam logic [9:0] IDX_CHF_LOW = 10'h300;
	localparam logic [9:0] IDX_STATUS = 10'h3F8;

	localparam logic [7:0] RST_CCA_OPT = 8'h00;
	localparam logic [7:0] RST_BUF_CFG = 8'h00;
	localparam logic [7:0] RST_PKT_FMT = 8'h04;
	localparam logic [7:0] RST_RX_DLY = 8'hC0;
	localparam logic [7:0] RST_TX_DLY = 8'hC0;
	localparam logic [7:0] RST_DLY_EXT = 8'h00;
	localparam logic [7:0] RST_FMT_SEL = 8'h00;
	localparam logic [7:0] RST_CHF_LOW = 8'h80;
	localparam logic [7:0] RST_CCA_THR = 8'hAB;

	localparam int B_CONT_CCA = 2;
	localparam int B_RX_AUTO_CCA = 1;
	localparam int B_DLY_BYPASS = 7;
	localparam int B_SEND_THEN_LISTEN = 3;
	localparam int B_LISTEN_THEN_SEND = 2;
	localparam int B_ADDON_EN = 4;
	localparam int B_SKIP_SYNTH = 3;
	localparam int B_FCS_BYPASS = 0;

	localparam logic [1:0] TXM_ONCE = 2'h0;
	localparam logic [1:0] TXM_RAMP = 2'h1;
	localparam logic [1:0] TXM_KEEP = 2'h3;
	localparam logic [1:0] RXM_FIRST = 2'h0;
	localparam logic [1:0] RXM_CONT = 2'h1;
	localparam logic [1:0] RXM_DROP = 2'h2;
	localparam logic [7:0] FMT_PACKET = 8'h00;
	localparam logic [7:0] FMT_SERIAL_SAMPLE_PORT_RX = 8'h02;
	localparam logic [7:0] FMT_SERIAL_SAMPLE_PORT_TX = 8'h03;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX_WAIT = 3'b001,
		ST_RX = 3'b010,
		ST_TX_WAIT = 3'b011,
		ST_TX = 3'b100
	} radio_state_t;

	typedef struct packed {
		logic pa_on;
		logic sfd_search;
		logic store_frame;
		logic fcs_auto;
		logic skip_synth;
		logic addon_en;
		logic serial_sample_port_rx;
		logic serial_sample_port_tx;
	} radio_ctrl_t;
endpackage : radio_seq_pkg

// file: core/period_tick.sv
// Purpose: free period counter giving one pulse per period while enabled
// Assumes: restarts from zero whenever enable is low
// Notes: used for continuous channel assessment
`timescale 1ns/1ps
module period_tick #(
	parameter int PERIOD = 25600
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic en,
	output logic tick
);
	logic [15:0] cnt_ff;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 16'h0000;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			tick <= 1'b0;
			if (!en)
				cnt_ff <= 16'h0000;
			else if (cnt_ff == 16'(PERIOD - 1))
			begin
				cnt_ff <= 16'h0000;
				tick <= 1'b1;
			end
			else
				cnt_ff <= cnt_ff + 16'h0001;
		end
	end
endmodule : period_tick

// file: core/delay_timer.sv
// Purpose: one-shot down counter in clock cycles
// Assumes: load wins over counting
// Notes: done pulses one cycle when count is at one or below
`timescale 1ns/1ps
module delay_timer #(
	parameter int W = 20
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] cycles,
	output logic done
);
	logic [W-1:0] cnt_ff;
	logic run_ff;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			done <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (load)
			begin
				cnt_ff <= cycles;
				run_ff <= 1'b1;
			end
			else if (run_ff)
			begin
				if (cnt_ff <= W'(1))
				begin
					run_ff <= 1'b0;
					done <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff - W'(1);
			end
		end
	end
endmodule : delay_timer

// file: core/radio_seq.sv
// Purpose: APB-mapped packet sequencer for a 2.4 GHz radio controller
// Assumes: rx_frame_end, tx_frame_end, rssi are driven by the modem core
// Notes: APB answers with zero wait states; unmapped reads return zero
`timescale 1ns/1ps
module radio_seq #(
	parameter int CCA_CYC = radio_seq_pkg::CCA_PERIOD_CYC,
	parameter int US_CYC = radio_seq_pkg::US_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic receive_command,
	input wire logic transmit_command,
	input wire logic rx_frame_end,
	input wire logic tx_frame_end,
	input wire logic [7:0] rssi,
	output logic cca_irq,
	output logic cca_clear,
	output radio_seq_pkg::radio_state_t state,
	output radio_seq_pkg::radio_ctrl_t ctrl,
	output logic [7:0] channel_frequency_word_low,
	output logic [7:0] packet_format_select
);
	localparam int DW = 20;

	logic [7:0] cca_opt_ff;
	logic [7:0] buf_cfg_ff;
	logic [7:0] pkt_fmt_ff;
	logic [7:0] rx_dly_ff;
	logic [7:0] tx_dly_ff;
	logic [7:0] dly_ext_ff;
	logic [7:0] cca_thr_ff;
	logic [9:0] idx;
	logic wr_en;
	logic rd_en;
	logic [31:0] nxt_rdata;
	logic dly_load;
	logic [DW-1:0] dly_cycles;
	logic dly_done;
	logic cca_tick;
	logic [15:0] rx_cca_ff;
	logic rx_cca_run_ff;
	logic cca_evt;
	radio_seq_pkg::radio_state_t nxt_state;

	// Start delay in cycles: base us plus extension in 4 us steps
	function automatic logic [DW-1:0] start_cycles(input logic [7:0] base, input logic [7:0] ext);
		logic [DW-1:0] us;
		us = DW'(base) * DW'(radio_seq_pkg::DLY_STEP_US) + DW'(ext) * DW'(radio_seq_pkg::EXT_STEP_US);
		start_cycles = (us == '0) ? DW'(1) : DW'(us * DW'(US_CYC));
	endfunction : start_cycles

	assign idx = paddr[11:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// Register writes, word aligned
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cca_opt_ff <= radio_seq_pkg::RST_CCA_OPT;
			buf_cfg_ff <= radio_seq_pkg::RST_BUF_CFG;
			pkt_fmt_ff <= radio_seq_pkg::RST_PKT_FMT;
			rx_dly_ff <= radio_seq_pkg::RST_RX_DLY;
			tx_dly_ff <= radio_seq_pkg::RST_TX_DLY;
			dly_ext_ff <= radio_seq_pkg::RST_DLY_EXT;
			packet_format_select <= radio_seq_pkg::RST_FMT_SEL;
			channel_frequency_word_low <= radio_seq_pkg::RST_CHF_LOW;
			cca_thr_ff <= radio_seq_pkg::RST_CCA_THR;
		end
		else if (ce && wr_en)
		begin
			if (idx == radio_seq_pkg::IDX_CCA_OPT)
				cca_opt_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_BUF_CFG)
				buf_cfg_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_PKT_FMT)
				pkt_fmt_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_RX_DLY)
				rx_dly_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_TX_DLY)
				tx_dly_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_DLY_EXT)
				dly_ext_ff <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_FMT_SEL)
				packet_format_select <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_CHF_LOW)
				channel_frequency_word_low <= pwdata[7:0];
			else if (idx == radio_seq_pkg::IDX_STATUS)
				cca_thr_ff <= pwdata[7:0];
		end
	end

	// Read mux, status word holds state, result and threshold
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (idx == radio_seq_pkg::IDX_CCA_OPT)
			nxt_rdata[7:0] = cca_opt_ff;
		else if (idx == radio_seq_pkg::IDX_BUF_CFG)
			nxt_rdata[7:0] = buf_cfg_ff;
		else if (idx == radio_seq_pkg::IDX_PKT_FMT)
			nxt_rdata[7:0] = pkt_fmt_ff;
		else if (idx == radio_seq_pkg::IDX_RX_DLY)
			nxt_rdata[7:0] = rx_dly_ff;
		else if (idx == radio_seq_pkg::IDX_TX_DLY)
			nxt_rdata[7:0] = tx_dly_ff;
		else if (idx == radio_seq_pkg::IDX_DLY_EXT)
			nxt_rdata[7:0] = dly_ext_ff;
		else if (idx == radio_seq_pkg::IDX_FMT_SEL)
			nxt_rdata[7:0] = packet_format_select;
		else if (idx == radio_seq_pkg::IDX_CHF_LOW)
			nxt_rdata[7:0] = channel_frequency_word_low;
		else if (idx == radio_seq_pkg::IDX_STATUS)
			nxt_rdata = {20'h00000, cca_clear, state, cca_thr_ff};
	end

	// Data latched in setup so it is stable in access; zero wait states
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (rd_en)
				prdata <= nxt_rdata;
		end
	end

	// Sequencer
	always_comb
	begin
		nxt_state = state;
		dly_load = 1'b0;
		dly_cycles = start_cycles(rx_dly_ff, dly_ext_ff);
		case (state)
			radio_seq_pkg::ST_IDLE:
			begin
				if (transmit_command)
				begin
					nxt_state = radio_seq_pkg::ST_TX_WAIT;
					dly_cycles = start_cycles(tx_dly_ff, dly_ext_ff);
					dly_load = 1'b1;
				end
				else if (receive_command)
				begin
					nxt_state = radio_seq_pkg::ST_RX_WAIT;
					dly_load = 1'b1;
				end
			end
			radio_seq_pkg::ST_RX_WAIT:
				if (dly_done)
					nxt_state = radio_seq_pkg::ST_RX;
			radio_seq_pkg::ST_TX_WAIT:
				if (dly_done)
					nxt_state = radio_seq_pkg::ST_TX;
			radio_seq_pkg::ST_RX:
			begin
				if (rx_frame_end)
				begin
					if (buf_cfg_ff[radio_seq_pkg::B_LISTEN_THEN_SEND])
					begin
						nxt_state = radio_seq_pkg::ST_TX_WAIT;
						dly_cycles = start_cycles(tx_dly_ff, dly_ext_ff);
						dly_load = 1'b1;
					end
					else if (buf_cfg_ff[1:0] == radio_seq_pkg::RXM_FIRST)
						nxt_state = radio_seq_pkg::ST_IDLE;
				end
			end
			radio_seq_pkg::ST_TX:
			begin
				if (tx_frame_end)
				begin
					dly_load = 1'b1;
					if (buf_cfg_ff[radio_seq_pkg::B_SEND_THEN_LISTEN])
						nxt_state = radio_seq_pkg::ST_RX_WAIT;
					else if (buf_cfg_ff[5:4] == radio_seq_pkg::TXM_RAMP
						|| buf_cfg_ff[5:4] == radio_seq_pkg::TXM_KEEP)
					begin
						nxt_state = radio_seq_pkg::ST_TX_WAIT;
						dly_cycles = start_cycles(tx_dly_ff, dly_ext_ff);
					end
					else
					begin
						nxt_state = radio_seq_pkg::ST_IDLE;
						dly_load = 1'b0;
					end
				end
			end
			default:
				nxt_state = radio_seq_pkg::ST_IDLE;
		endcase
		// Bypass: one-cycle wait instead of programmed delay
		if (buf_cfg_ff[radio_seq_pkg::B_DLY_BYPASS])
			dly_cycles = DW'(1);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state <= radio_seq_pkg::ST_IDLE;
		else if (ce)
			state <= nxt_state;
	end

	delay_timer #(.W(DW)) u_start_dly (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.load(dly_load),
		.cycles(dly_cycles),
		.done(dly_done)
	);

	// Datapath controls; mode 1 drops PA between packets, mode 3 holds it
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl <= '0;
		else if (ce)
		begin
			ctrl.pa_on <= (nxt_state == radio_seq_pkg::ST_TX)
				|| (nxt_state == radio_seq_pkg::ST_TX_WAIT && (state == radio_seq_pkg::ST_TX || ctrl.pa_on)
				&& buf_cfg_ff[5:4] == radio_seq_pkg::TXM_KEEP);
			ctrl.sfd_search <= (nxt_state == radio_seq_pkg::ST_RX);
			ctrl.store_frame <= (buf_cfg_ff[1:0] == radio_seq_pkg::RXM_FIRST
				|| buf_cfg_ff[1:0] == radio_seq_pkg::RXM_CONT);
			ctrl.fcs_auto <= !pkt_fmt_ff[radio_seq_pkg::B_FCS_BYPASS];
			ctrl.skip_synth <= pkt_fmt_ff[radio_seq_pkg::B_SKIP_SYNTH];
			ctrl.addon_en <= pkt_fmt_ff[radio_seq_pkg::B_ADDON_EN];
			ctrl.serial_sample_port_rx <= (packet_format_select == radio_seq_pkg::FMT_SERIAL_SAMPLE_PORT_RX);
			ctrl.serial_sample_port_tx <= (packet_format_select == radio_seq_pkg::FMT_SERIAL_SAMPLE_PORT_TX);
		end
	end

	// Continuous assessment ticks
	period_tick #(.PERIOD(CCA_CYC)) u_cca_period (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.en(cca_opt_ff[radio_seq_pkg::B_CONT_CCA]),
		.tick(cca_tick)
	);

	// One-shot assessment after entering receive
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cca_ff <= 16'h0000;
			rx_cca_run_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (nxt_state == radio_seq_pkg::ST_RX && state != radio_seq_pkg::ST_RX
				&& cca_opt_ff[radio_seq_pkg::B_RX_AUTO_CCA])
			begin
				rx_cca_ff <= 16'(CCA_CYC - 1);
				rx_cca_run_ff <= 1'b1;
			end
			else if (rx_cca_run_ff)
			begin
				if (rx_cca_ff == 16'h0000)
					rx_cca_run_ff <= 1'b0;
				else
					rx_cca_ff <= rx_cca_ff - 16'h0001;
			end
		end
	end

	assign cca_evt = cca_tick || (rx_cca_run_ff && rx_cca_ff == 16'h0000);

	// Assessment result and interrupt pulse
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cca_irq <= 1'b0;
			cca_clear <= 1'b0;
		end
		else if (ce)
		begin
			cca_irq <= cca_evt;
			if (cca_evt)
				cca_clear <= ($signed(rssi) < $signed(cca_thr_ff));
		end
	end

	property p_cont_off;
		@(posedge mclk) disable iff (!rst_n)
		(!cca_opt_ff[radio_seq_pkg::B_CONT_CCA] && !rx_cca_run_ff && ce) [*2] |=> !cca_irq;
	endproperty
	a_cont_off: assert property (p_cont_off) else $error("periodic irq while disabled");

	property p_once_idle;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_TX && tx_frame_end && buf_cfg_ff[5:4] == radio_seq_pkg::TXM_ONCE
		&& !buf_cfg_ff[radio_seq_pkg::B_SEND_THEN_LISTEN]) |=> state == radio_seq_pkg::ST_IDLE;
	endproperty
	a_once_idle: assert property (p_once_idle) else $error("mode 0 did not return idle");

	property p_repeat;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_TX && tx_frame_end && buf_cfg_ff[4]
		&& !buf_cfg_ff[radio_seq_pkg::B_SEND_THEN_LISTEN]) |=> state == radio_seq_pkg::ST_TX_WAIT;
	endproperty
	a_repeat: assert property (p_repeat) else $error("cyclic mode did not repeat");

	property p_keep_pa;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_TX && tx_frame_end && buf_cfg_ff[5:4] == radio_seq_pkg::TXM_KEEP
		&& !buf_cfg_ff[radio_seq_pkg::B_SEND_THEN_LISTEN]) |=> ctrl.pa_on [*2];
	endproperty
	a_keep_pa: assert property (p_keep_pa) else $error("PA dropped in mode 3");

	property p_send_listen;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_TX && tx_frame_end && buf_cfg_ff[radio_seq_pkg::B_SEND_THEN_LISTEN])
		|=> state == radio_seq_pkg::ST_RX_WAIT;
	endproperty
	a_send_listen: assert property (p_send_listen) else $error("no turnaround to receive");

	property p_listen_send;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_RX && rx_frame_end && buf_cfg_ff[radio_seq_pkg::B_LISTEN_THEN_SEND])
		|=> state == radio_seq_pkg::ST_TX_WAIT;
	endproperty
	a_listen_send: assert property (p_listen_send) else $error("no turnaround to transmit");

	property p_bypass;
		@(posedge mclk) disable iff (!rst_n)
		(ce && state == radio_seq_pkg::ST_IDLE && transmit_command && buf_cfg_ff[radio_seq_pkg::B_DLY_BYPASS])
		##1 ce [*2] |=> state == radio_seq_pkg::ST_TX;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not skip delay");

	property p_fcs;
		@(posedge mclk) disable iff (!rst_n)
		(ce && rst_n) |=> (ctrl.fcs_auto == !$past(pkt_fmt_ff[radio_seq_pkg::B_FCS_BYPASS]));
	endproperty
	a_fcs: assert property (p_fcs) else $error("fcs control mismatch");
endmodule : radio_seq

// file: bench/modem_model.sv
// Purpose: modem stand-in that ends a frame a set time into rx or tx
// Assumes: frame ends are only given while receiving or sending
// Notes: frame_len picks a prompt or a slow far side
`timescale 1ns/1ps
module modem_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire radio_seq_pkg::radio_state_t state,
	input wire logic [9:0] frame_len,
	output logic rx_frame_end,
	output logic tx_frame_end
);
	logic [9:0] cnt_ff;
	logic busy;
	assign busy = (state == radio_seq_pkg::ST_RX) || (state == radio_seq_pkg::ST_TX);
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 10'h000;
			rx_frame_end <= 1'b0;
			tx_frame_end <= 1'b0;
		end
		else
		begin
			cnt_ff <= (!busy || cnt_ff == frame_len) ? 10'h000 : cnt_ff + 10'h001;
			// Pulses only inside a frame state, never while waiting
			rx_frame_end <= busy && cnt_ff == frame_len && state == radio_seq_pkg::ST_RX;
			tx_frame_end <= busy && cnt_ff == frame_len && state == radio_seq_pkg::ST_TX;
		end
	end
endmodule : modem_model

// file: bench/radio_packet_sequencing_config_bench.sv
// Purpose: self-checking bench for the radio packet sequencer
// Assumes: zero-wait APB slave, shortened assessment and microsecond counts
// Notes: every sequencer case starts from a fresh reset
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module radio_packet_sequencing_config_bench;
	localparam int CCA = 64;
	localparam int US = 2;
	typedef struct packed {logic [11:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] b;} reg_row_t;
	typedef struct packed {logic tx; logic [7:0] cfg; radio_seq_pkg::radio_state_t st; logic chk; logic aux;} seq_row_t;
	typedef struct packed {logic tx; logic byp; logic [7:0] d; logic [7:0] e;} dly_row_t;
	logic mclk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic receive_command, transmit_command, rx_frame_end, tx_frame_end, cca_irq, cca_clear;
	logic [7:0] rssi, chf_low, fmt_sel;
	logic [7:0] fmts [3] = '{8'h00, 8'h02, 8'h03};
	logic [9:0] frame_len;
	radio_seq_pkg::radio_state_t state;
	radio_seq_pkg::radio_ctrl_t ctrl;
	int fail_count, checks, cycles, n, w;
	logic ok;
	// Reserved fields kept at defaults; add-on and skip only with cyclic transmit
	reg_row_t regs [9] = '{'{12'h418, 8'h00, 8'h06, 8'h06}, '{12'h41C, 8'h00, 8'hB5, 8'hB5},
		'{12'h420, 8'h04, 8'h1D, 8'h1D}, '{12'h424, 8'hC0, 8'h33, 8'h33}, '{12'h428, 8'hC0, 8'h44, 8'h44},
		'{12'h42C, 8'h00, 8'h55, 8'h55}, '{12'h4F8, 8'h00, 8'h02, 8'h02}, '{12'hC00, 8'h80, 8'h3C, 8'h3C},
		'{12'h010, 8'h00, 8'hFF, 8'h00}};
	// Rows: mode 0, 1, 3, send-then-listen, rx 0, 1, 2, listen-then-send
	seq_row_t seqs [8] = '{'{1'b1, 8'h00, radio_seq_pkg::ST_IDLE, 1'b1, 1'b0},
		'{1'b1, 8'h10, radio_seq_pkg::ST_TX_WAIT, 1'b1, 1'b0}, '{1'b1, 8'h30, radio_seq_pkg::ST_TX_WAIT, 1'b1, 1'b1},
		'{1'b1, 8'h08, radio_seq_pkg::ST_RX_WAIT, 1'b0, 1'b0}, '{1'b0, 8'h00, radio_seq_pkg::ST_IDLE, 1'b1, 1'b1},
		'{1'b0, 8'h01, radio_seq_pkg::ST_RX, 1'b1, 1'b1}, '{1'b0, 8'h02, radio_seq_pkg::ST_RX, 1'b1, 1'b0},
		'{1'b0, 8'h04, radio_seq_pkg::ST_TX_WAIT, 1'b0, 1'b0}};
	dly_row_t dls [6] = '{'{1'b1, 1'b0, 8'h03, 8'h00}, '{1'b1, 1'b0, 8'h03, 8'h01}, '{1'b1, 1'b0, 8'h00, 8'h00},
		'{1'b0, 1'b0, 8'h05, 8'h01}, '{1'b1, 1'b1, 8'h03, 8'h01}, '{1'b0, 1'b1, 8'h05, 8'h01}};

	radio_seq #(.CCA_CYC(CCA), .US_CYC(US)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .receive_command(receive_command), .transmit_command(transmit_command),
		.rx_frame_end(rx_frame_end), .tx_frame_end(tx_frame_end), .rssi(rssi), .cca_irq(cca_irq),
		.cca_clear(cca_clear), .state(state), .ctrl(ctrl), .channel_frequency_word_low(chf_low),
		.packet_format_select(fmt_sel));
	modem_model i_modem (.mclk(mclk), .rst_n(rst_n), .state(state), .frame_len(frame_len),
		.rx_frame_end(rx_frame_end), .tx_frame_end(tx_frame_end));

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			results;
		end
	end

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		`CHK("pslverr", 1'b0, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic do_reset;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
	endtask : do_reset

	task automatic cmd(input logic tx);
		@(posedge mclk);
		transmit_command <= tx;
		receive_command <= !tx;
		@(posedge mclk);
		transmit_command <= 1'b0;
		receive_command <= 1'b0;
	endtask : cmd

	task automatic wait_st(input radio_seq_pkg::radio_state_t s);
		n = 0;
		while (state !== s)
		begin
			@(posedge mclk);
			n++;
		end
	endtask : wait_st

	task automatic count_irq(input int len);
		n = 0;
		repeat (len)
		begin
			@(posedge mclk);
			if (cca_irq === 1'b1)
				n++;
		end
	endtask : count_irq

	initial
	begin
		{psel, penable, pwrite, receive_command, transmit_command} = 5'h00;
		ce = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		rssi = 8'h00;
		frame_len = 10'h014;
		rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		`CHK("ctrl after reset", 8'h30, ctrl)
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b0, regs[i].a, 8'h00);
			`CHK("reset value", {24'h000000, regs[i].r}, rd)
			apb(1'b1, regs[i].a, regs[i].w);
			apb(1'b0, regs[i].a, 8'h00);
			`CHK("read back", {24'h000000, regs[i].b}, rd)
		end
		`CHK("freq low out", 8'h3C, chf_low)
		`CHK("fcs auto", 1'b0, ctrl.fcs_auto)
		`CHK("skip synth", 1'b1, ctrl.skip_synth)
		`CHK("addon", 1'b1, ctrl.addon_en)
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, 12'h4F8, fmts[i]);
			@(posedge mclk);
			#1;
			`CHK("format", fmts[i], fmt_sel)
			`CHK("serial_sample_port rx", fmts[i] == 8'h02, ctrl.serial_sample_port_rx)
			`CHK("serial_sample_port tx", fmts[i] == 8'h03, ctrl.serial_sample_port_tx)
		end
		for (int i = 0; i < 8; i++)
		begin
			do_reset;
			apb(1'b1, 12'h41C, seqs[i].cfg);
			apb(1'b1, 12'h424, 8'h02);
			apb(1'b1, 12'h428, 8'h02);
			cmd(seqs[i].tx);
			wait_st(seqs[i].tx ? radio_seq_pkg::ST_TX : radio_seq_pkg::ST_RX);
			if (!seqs[i].tx && seqs[i].chk)
				`CHK("store frame", seqs[i].aux, ctrl.store_frame)
			if (!seqs[i].tx)
				`CHK("sfd search", 1'b1, ctrl.sfd_search)
			@(posedge mclk);
			while (rx_frame_end !== 1'b1 && tx_frame_end !== 1'b1)
				@(posedge mclk);
			#1;
			`CHK("state after frame", seqs[i].st, state)
			if (seqs[i].tx && seqs[i].chk)
			begin
				`CHK("pa between frames", seqs[i].aux, ctrl.pa_on)
				@(posedge mclk);
				#1;
				`CHK("pa held", seqs[i].aux, ctrl.pa_on)
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			do_reset;
			apb(1'b1, 12'h424, dls[i].d);
			apb(1'b1, 12'h428, dls[i].d);
			apb(1'b1, 12'h42C, dls[i].e);
			apb(1'b1, 12'h41C, {dls[i].byp, 7'h00});
			cmd(dls[i].tx);
			wait_st(dls[i].tx ? radio_seq_pkg::ST_TX : radio_seq_pkg::ST_RX);
			w = (int'(dls[i].d) + 4 * int'(dls[i].e)) * US;
			w = (w == 0) ? 1 : w;
			ok = dls[i].byp ? (n <= 4) : (n >= w && n <= w + 3);
			`CHK("start delay", 1'b1, ok)
		end
		do_reset;
		rssi <= 8'hA0;
		apb(1'b1, 12'h418, 8'h04);
		count_irq(CCA * 4 + 32);
		`CHK("periodic count", 4, n)
		`CHK("clear channel", 1'b1, cca_clear)
		rssi <= 8'h10;
		count_irq(CCA + 8);
		`CHK("busy channel", 1'b0, cca_clear)
		apb(1'b1, 12'h418, 8'h00);
		count_irq(CCA * 2);
		`CHK("periodic off", 0, n)
		do_reset;
		frame_len <= 10'h1F4;
		apb(1'b1, 12'h41C, 8'h01);
		apb(1'b1, 12'h424, 8'h00);
		apb(1'b1, 12'h418, 8'h02);
		cmd(1'b0);
		wait_st(radio_seq_pkg::ST_RX);
		count_irq(CCA - 3);
		`CHK("no early irq", 0, n)
		count_irq(6);
		`CHK("one irq", 1, n)
		count_irq(CCA * 2);
		`CHK("single shot", 0, n)
		// Clock enable low: command ignored, outputs frozen
		do_reset;
		ce <= 1'b0;
		cmd(1'b1);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("frozen state", radio_seq_pkg::ST_IDLE, state)
		`CHK("frozen ctrl", 8'h00, ctrl)
		@(posedge mclk);
		ce <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("ctrl after enable", 8'h30, ctrl)
		results;
	end
endmodule : radio_packet_sequencing_config_bench
